//--- dpb_regs.svh
`ifndef DPB_REGS_SVH
`define DPB_REGS_SVH

// widest address of the family, and the default variant
`define DPB_AW_MAX   18
`define DPB_AW_DEF   17
// data word split into byte lanes
`define DPB_DATA_W   36
`define DPB_LANES    4
`define DPB_LANE_W   9
// reset values of the flags, high means idle, and of the burst counter
`define DPB_FLAG_RST 1'b1
`define DPB_CNT_RST  18'h00000
// readback idle level of the address enable
`define DPB_OE_OFF   1'b1

`endif

//--- dpb_pkg.sv
`include "dpb_regs.svh"

package dpb_pkg;

   typedef logic [`DPB_AW_MAX-1:0] dpb_adr_t;
   typedef logic [`DPB_DATA_W-1:0] dpb_word_t;
   typedef logic [`DPB_LANES-1:0]  dpb_lane_t;

   // pins driven into one port by its host
   typedef struct packed {
      dpb_adr_t  adr;
      logic      addr_latch_strobe_n;
      logic      chip_sel_low_active_n;
      logic      chip_sel_high_active;
      logic      burst_step_enable_n;
      logic      burst_clear_n;
      logic      mask_access_select;
      logic      rd_wr_n;
      dpb_lane_t byte_lane_select_n;
      logic      out_enable_n;
      dpb_word_t dq;
   } dpb_pin_in_s;

   // pins driven by one port toward its host
   typedef struct packed {
      dpb_word_t dq;
      dpb_lane_t dq_oe_n;
      dpb_adr_t  adr;
      logic      adr_oe_n;
      logic      mailbox_flag_n;
      logic      wrap_flag_n;
   } dpb_pin_out_s;

   typedef struct packed {
      dpb_adr_t cnt;
      dpb_adr_t mask;
      dpb_adr_t rb;
      logic     rb_oe_n;
      logic     wrap_n;
   } dpb_ctr_state_s;

   typedef struct packed {
      dpb_pin_in_s [1:0] in;
      logic        [1:0] rd_vld;
      dpb_lane_t   [1:0] rd_lane;
      dpb_word_t   [1:0] dq;
      logic        [1:0] mbox_n;
   } dpb_top_state_s;

endpackage : dpb_pkg

//--- dpb_mem.sv
`timescale 1ns/10ps
`default_nettype none
`include "dpb_regs.svh"

module dpb_mem #(
   parameter int ADDR_W = `DPB_AW_DEF
) (
   input  wire logic                       i_clk,
   input  wire logic                       i_ce,
   input  wire logic      [1:0]            i_we,
   input  wire dpb_pkg::dpb_lane_t [1:0]   i_lane,
   input  wire logic      [1:0][ADDR_W-1:0] i_adr,
   input  wire dpb_pkg::dpb_word_t [1:0]   i_wd,
   output var  dpb_pkg::dpb_word_t [1:0]   o_rd
);
   import dpb_pkg::*;

   // array holds no reset: contents are undefined until written
   dpb_word_t mem [2**ADDR_W];

   always_ff @(posedge i_clk) begin
      if (i_ce) begin
         // port 1 after port 0: on a same-word collision port 1 wins its lanes
         for (int p = 0; p < 2; p++) begin
            if (i_we[p]) begin
               for (int l = 0; l < `DPB_LANES; l++) begin
                  if (i_lane[p][l]) begin
                     mem[i_adr[p]][l*`DPB_LANE_W +: `DPB_LANE_W] <=
                        i_wd[p][l*`DPB_LANE_W +: `DPB_LANE_W];
                  end
               end
            end
         end
      end
   end

   always_comb begin
      for (int p = 0; p < 2; p++) begin
         o_rd[p] = mem[i_adr[p]];
      end
   end

endmodule : dpb_mem

`default_nettype wire

//--- dpb_burst_ctr.sv
`timescale 1ns/10ps
`default_nettype none
`include "dpb_regs.svh"

module dpb_burst_ctr #(
   parameter int ADDR_W    = `DPB_AW_DEF,
   parameter bit HAS_BURST = 1'b1
) (
   input  wire logic                 i_clk,
   input  wire logic                 i_nrst,
   input  wire logic                 i_ce,
   input  wire dpb_pkg::dpb_pin_in_s i_pin,
   output var  logic [ADDR_W-1:0]    o_acc_adr,
   output var  dpb_pkg::dpb_adr_t    o_rb_adr,
   output var  logic                 o_rb_oe_n,
   output var  logic                 o_wrap_n
);
   import dpb_pkg::*;

   localparam dpb_adr_t SPAN = `DPB_AW_MAX'((19'h1 << ADDR_W) - 19'h1);

   dpb_ctr_state_s s_q;
   dpb_ctr_state_s s_d;
   dpb_adr_t       inc;

   // masked bits forced to one so the carry skips them
   function automatic dpb_adr_t bump(input dpb_adr_t c, input dpb_adr_t m);
      return (((c | ~m | ~SPAN) + 1'b1) & m & SPAN) | (c & ~m);
   endfunction : bump

   always_comb begin
      s_d       = s_q;
      s_d.rb_oe_n = `DPB_OE_OFF;
      inc       = bump(s_q.cnt, s_q.mask);
      if (HAS_BURST) begin
         if (!i_pin.mask_access_select) begin
            if (!i_pin.burst_clear_n) begin
               s_d.mask = SPAN;
            end else if (!i_pin.addr_latch_strobe_n && !i_pin.burst_step_enable_n) begin
               s_d.mask = i_pin.adr & SPAN;
            end else if (!i_pin.addr_latch_strobe_n) begin
               s_d.rb      = s_q.mask;
               s_d.rb_oe_n = 1'b0;
            end
         end else if (!i_pin.burst_clear_n) begin
            s_d.cnt    = s_q.cnt & ~s_q.mask;
            s_d.wrap_n = `DPB_FLAG_RST;
         end else if (!i_pin.addr_latch_strobe_n) begin
            if (!i_pin.burst_step_enable_n) begin
               s_d.cnt    = i_pin.adr & SPAN;
               s_d.wrap_n = `DPB_FLAG_RST;
            end else begin
               s_d.rb      = s_q.cnt;
               s_d.rb_oe_n = 1'b0;
            end
         end else if (!i_pin.burst_step_enable_n) begin
            s_d.cnt    = inc;
            s_d.wrap_n = ((inc | ~s_q.mask | ~SPAN) != '1);
         end
      end
   end

   // strobe selects the pins, else the counter
   assign o_acc_adr = (HAS_BURST && i_pin.addr_latch_strobe_n) ? s_d.cnt[ADDR_W-1:0]
                                                              : i_pin.adr[ADDR_W-1:0];
   assign o_rb_adr  = s_q.rb;
   assign o_rb_oe_n = s_q.rb_oe_n;
   assign o_wrap_n  = s_q.wrap_n;

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         s_q         <= '0;
         s_q.cnt     <= `DPB_CNT_RST;
         s_q.mask    <= SPAN;
         s_q.rb_oe_n <= `DPB_OE_OFF;
         s_q.wrap_n  <= `DPB_FLAG_RST;
      end else if (i_ce) begin
         s_q <= s_d;
      end
   end

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_nrst);

   wire cnt_op = HAS_BURST && i_ce && i_pin.mask_access_select;

   clear_zero_a: assert property (
      cnt_op && !i_pin.burst_clear_n
      |=> (s_q.cnt & s_q.mask) == '0 && s_q.cnt == $past(s_q.cnt & ~s_q.mask))
      else $error("counter clear left unmasked bits set");

   step_adv_a: assert property (
      cnt_op && i_pin.burst_clear_n && i_pin.addr_latch_strobe_n
      && !i_pin.burst_step_enable_n |=> s_q.cnt == $past(inc))
      else $error("counter did not step");

   wrap_low_a: assert property (
      cnt_op && i_pin.burst_clear_n && i_pin.addr_latch_strobe_n
      && !i_pin.burst_step_enable_n && ((inc | ~s_q.mask | ~SPAN) == '1)
      |=> !o_wrap_n)
      else $error("wrap flag missed all-ones");

   mask_load_a: assert property (
      HAS_BURST && i_ce && !i_pin.mask_access_select && i_pin.burst_clear_n
      && !i_pin.addr_latch_strobe_n && !i_pin.burst_step_enable_n
      |=> s_q.mask == $past(i_pin.adr & SPAN) && $stable(s_q.cnt))
      else $error("mask load failed");

   reset_val_a: assert property (
      $rose(i_nrst) |-> s_q.cnt == '0 && s_q.mask == SPAN && o_wrap_n)
      else $error("counter reset values wrong");

endmodule : dpb_burst_ctr

`default_nettype wire

//--- dpb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "dpb_regs.svh"

module dpb_top #(
   parameter int ADDR_W = `DPB_AW_DEF
) (
   input  wire logic                  i_clk,
   input  wire logic                  i_nrst,
   input  wire logic                  i_ce,
   input  wire dpb_pkg::dpb_pin_in_s  i_port_l,
   input  wire dpb_pkg::dpb_pin_in_s  i_port_r,
   output var  dpb_pkg::dpb_pin_out_s o_port_l,
   output var  dpb_pkg::dpb_pin_out_s o_port_r
);
   import dpb_pkg::*;

   // widest variant has no counter pins
   localparam bit HAS_BURST = (ADDR_W < `DPB_AW_MAX);

   dpb_top_state_s           s_q;
   dpb_top_state_s           s_d;
   dpb_pin_in_s  [1:0]       pin;
   dpb_pin_out_s [1:0]       pout;
   logic [1:0][ADDR_W-1:0]   acc;
   dpb_adr_t     [1:0]       rb_adr;
   logic         [1:0]       rb_oe_n;
   logic         [1:0]       wrap_n;
   dpb_word_t    [1:0]       rdata;
   dpb_word_t    [1:0]       wd;
   dpb_lane_t    [1:0]       lanes;
   logic         [1:0]       sel;
   logic         [1:0]       wr;
   logic         [1:0]       rd;
   logic         [1:0]       mb_set;
   logic         [1:0]       mb_clr;

   assign pin[0]   = i_port_l;
   assign pin[1]   = i_port_r;
   assign o_port_l = pout[0];
   assign o_port_r = pout[1];

   // port 1 (right) owns the top word
   function automatic logic [ADDR_W-1:0] mbox_adr(input int p);
      return (p == 1) ? {ADDR_W{1'b1}} : {{(ADDR_W-1){1'b1}}, 1'b0};
   endfunction : mbox_adr

   // widen lane selects into a bit mask of the word
   function automatic dpb_word_t lane_mask(input dpb_lane_t l);
      dpb_word_t m;
      m = '0;
      for (int i = 0; i < `DPB_LANES; i++) begin
         m[i*`DPB_LANE_W +: `DPB_LANE_W] = {`DPB_LANE_W{l[i]}};
      end
      return m;
   endfunction : lane_mask

   generate
      for (genvar p = 0; p < 2; p++) begin : g_port
         dpb_burst_ctr #(
            .ADDR_W    (ADDR_W),
            .HAS_BURST (HAS_BURST)
         ) u_ctr (
            .i_clk     (i_clk),
            .i_nrst    (i_nrst),
            .i_ce      (i_ce),
            .i_pin     (s_q.in[p]),
            .o_acc_adr (acc[p]),
            .o_rb_adr  (rb_adr[p]),
            .o_rb_oe_n (rb_oe_n[p]),
            .o_wrap_n  (wrap_n[p])
         );
      end
   endgenerate

   dpb_mem #(
      .ADDR_W (ADDR_W)
   ) u_mem (
      .i_clk  (i_clk),
      .i_ce   (i_ce),
      .i_we   (wr),
      .i_lane (lanes),
      .i_adr  (acc),
      .i_wd   (wd),
      .o_rd   (rdata)
   );

   always_comb begin
      s_d = s_q;
      for (int p = 0; p < 2; p++) begin
         // all port pins but the output enable take one register stage
         s_d.in[p] = pin[p];
         // either select off deselects the port; without counter pins it is always selected
         sel[p]    = !s_q.in[p].chip_sel_low_active_n
                     && (s_q.in[p].chip_sel_high_active || !HAS_BURST);
         if (!HAS_BURST) begin
            sel[p] = 1'b1;
         end
         lanes[p]  = ~s_q.in[p].byte_lane_select_n;
         wd[p]     = s_q.in[p].dq;
         // write strobe from the sampled select, high for every cycle it is held
         wr[p]     = sel[p] && !s_q.in[p].rd_wr_n && (|lanes[p]);
         rd[p]     = sel[p] && s_q.in[p].rd_wr_n;
         // read data held exactly one cycle
         s_d.rd_vld[p]  = rd[p];
         s_d.rd_lane[p] = lanes[p];
         s_d.dq[p]      = rdata[p] & lane_mask(lanes[p]);
      end
      for (int p = 0; p < 2; p++) begin
         mb_set[p] = wr[1-p] && (acc[1-p] == mbox_adr(p));
         mb_clr[p] = rd[p] && (|lanes[p]) && (acc[p] == mbox_adr(p));
         // a new message wins over a clearing read
         if (mb_set[p]) begin
            s_d.mbox_n[p] = 1'b0;
         end else if (mb_clr[p]) begin
            s_d.mbox_n[p] = `DPB_FLAG_RST;
         end
      end
   end

   always_comb begin
      for (int p = 0; p < 2; p++) begin
         pout[p].dq             = s_q.dq[p];
         pout[p].dq_oe_n        = ~(s_q.rd_lane[p]
                                    & {`DPB_LANES{s_q.rd_vld[p] && !pin[p].out_enable_n}});
         pout[p].adr            = rb_adr[p];
         pout[p].adr_oe_n       = rb_oe_n[p];
         pout[p].mailbox_flag_n = s_q.mbox_n[p];
         pout[p].wrap_flag_n    = wrap_n[p];
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         s_q        <= '0;
         s_q.mbox_n <= {2{`DPB_FLAG_RST}};
      end else if (i_ce) begin
         s_q <= s_d;
      end
   end

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_nrst);

   sequence s_read_req(int p);
      i_ce && rd[p] && (|lanes[p]);
   endsequence

   sequence s_quiet_pins(int p);
      i_ce && HAS_BURST && pin[p].chip_sel_high_active == 1'b0;
   endsequence

   read_data_a: assert property (
      s_read_req(0) ##1 (i_ce && !pin[0].out_enable_n)
      |-> (pout[0].dq_oe_n == ~$past(lanes[0])) && pout[0].dq == $past(s_d.dq[0]))
      else $error("left read data not presented");

   desel_off_a: assert property (
      s_quiet_pins(1) ##1 i_ce ##1 i_ce |-> &pout[1].dq_oe_n)
      else $error("deselected port still drives");

   oe_async_a: assert property (
      pin[0].out_enable_n || !s_q.rd_vld[0] |-> &pout[0].dq_oe_n)
      else $error("data driven without output enable");

   mbox_set_a: assert property (
      i_ce && wr[0] && acc[0] == mbox_adr(1) |=> !pout[1].mailbox_flag_n)
      else $error("right mailbox flag not lowered");

   mbox_clr_a: assert property (
      i_ce && mb_clr[0] && !mb_set[0] |=> pout[0].mailbox_flag_n)
      else $error("left mailbox flag not raised");

   mbox_lane_a: assert property (
      i_ce && sel[1] && !s_q.in[1].rd_wr_n && lanes[1] == '0 && !mb_clr[0]
      |=> pout[0].mailbox_flag_n == $past(pout[0].mailbox_flag_n))
      else $error("laneless write moved a flag");

   property p_wr_rd;
      logic [ADDR_W-1:0] a;
      dpb_word_t         d;
      (i_ce && wr[0] && (&lanes[0]), a = acc[0], d = wd[0])
      ##1 (i_ce && acc[0] == a && !wr[1]) |-> rdata[0] == d;
   endproperty
   wr_rd_a: assert property (p_wr_rd)
      else $error("written word not read back");

   wr_pulse_a: assert property (
      i_ce && wr[0] ##1 i_ce && $past(pin[0].chip_sel_low_active_n) |-> !wr[0])
      else $error("write strobe outlived select");

endmodule : dpb_top

`default_nettype wire

//--- dpb_host.sv
`timescale 1ns/10ps
`default_nettype none

module dpb_host (
   input  wire logic                 i_clk,
   input  wire logic                 i_oe_off,
   output var  dpb_pkg::dpb_pin_in_s o_pin
);
   import dpb_pkg::*;

   dpb_pin_in_s pin_q;

   // idle host keeps the port deselected
   function automatic dpb_pin_in_s idle();
      idle = '0;
      idle.addr_latch_strobe_n = 1'b1;
      idle.chip_sel_low_active_n = 1'b1;
      idle.burst_step_enable_n = 1'b1;
      idle.burst_clear_n = 1'b1;
      idle.mask_access_select = 1'b1;
      idle.rd_wr_n = 1'b1;
      idle.byte_lane_select_n = 4'hf;
   endfunction : idle

   initial pin_q = idle();

   always_comb begin
      o_pin = pin_q;
      o_pin.out_enable_n = pin_q.out_enable_n | i_oe_off;
   end

   task automatic drive(input dpb_pin_in_s p);
      @(posedge i_clk);
      // host inverts its last data lines when not writing
      if (p.rd_wr_n) begin
         p.dq = ~pin_q.dq;
      end
      pin_q <= p;
   endtask : drive
endmodule : dpb_host

`default_nettype wire

//--- test_dual_port_burst_sram_ports.sv
`timescale 1ns/10ps
`default_nettype none

module test_dual_port_burst_sram_ports;
   import dpb_pkg::*;

   localparam logic [17:0] TOP = 18'h1ffff;

   logic         i_clk;
   logic         i_nrst;
   logic         oe_off;
   logic         ce;
   dpb_pin_in_s  pin_l;
   dpb_pin_in_s  pin_r;
   dpb_pin_out_s out_l;
   dpb_pin_out_s out_r;
   int           mismatches;
   int           tests_run;
   logic [17:0]  a;
   dpb_word_t    d1;
   dpb_word_t    d2;
   dpb_lane_t    m;
   dpb_lane_t    r;

   dpb_host hl (.i_clk(i_clk), .i_oe_off(oe_off), .o_pin(pin_l));
   dpb_host hr (.i_clk(i_clk), .i_oe_off(1'b0), .o_pin(pin_r));

   dpb_top #(.ADDR_W(17)) dut (
      .i_clk(i_clk), .i_nrst(i_nrst), .i_ce(ce), .i_port_l(pin_l),
      .i_port_r(pin_r), .o_port_l(out_l), .o_port_r(out_r));

   task automatic chk(input logic [35:0] got, input logic [35:0] exp);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic close_out;
      $display("comparisons %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : close_out

   function automatic dpb_word_t lane_mix(dpb_word_t x, dpb_word_t y, dpb_lane_t sel_n);
      lane_mix = x;
      for (int i = 0; i < 4; i++) begin
         if (!sel_n[i]) begin
            lane_mix[9*i +: 9] = y[9*i +: 9];
         end
      end
   endfunction : lane_mix

   function automatic dpb_pin_in_s acc(logic rw, logic [17:0] ad, dpb_lane_t ln, dpb_word_t w);
      acc = hl.idle();
      acc.chip_sel_low_active_n = 1'b0;
      acc.chip_sel_high_active = 1'b1;
      acc.addr_latch_strobe_n = 1'b0;
      acc.burst_step_enable_n = 1'b0;
      acc.rd_wr_n = rw;
      acc.adr = ad;
      acc.byte_lane_select_n = ln;
      acc.dq = w;
   endfunction : acc

   function automatic dpb_word_t rword();
      rword[35:32] = 4'($urandom);
      rword[31:0] = $urandom;
   endfunction : rword

   function automatic logic flag(bit s);
      flag = s ? out_r.mailbox_flag_n : out_l.mailbox_flag_n;
   endfunction : flag

   // only one port is ever given a write, the other idles
   task automatic put(input bit s, input dpb_pin_in_s p);
      fork
         hl.drive(s ? hl.idle() : p);
         hr.drive(s ? p : hl.idle());
      join
   endtask : put

   task automatic rd(input bit s, input logic [17:0] ad, input dpb_lane_t ln, input dpb_word_t e);
      put(s, acc(1'b1, ad, ln, '0));
      put(s, hl.idle());
      @(posedge i_clk);
      #1;
      chk(s ? out_r.dq : out_l.dq, e);
      chk(s ? out_r.dq_oe_n : out_l.dq_oe_n, ln);
      @(posedge i_clk);
      #1;
      chk(s ? out_r.dq_oe_n : out_l.dq_oe_n, 4'hf);
   endtask : rd

   // strobe and step drive counter operations on the left port
   task automatic ctl(input logic ms, input logic cl, input logic st, input logic sp,
                      input logic [17:0] ad);
      dpb_pin_in_s p;
      p = hl.idle();
      p.mask_access_select = ms;
      p.burst_clear_n = cl;
      p.addr_latch_strobe_n = st;
      p.burst_step_enable_n = sp;
      p.adr = ad;
      put(1'b0, p);
   endtask : ctl

   task automatic rb(input logic ms, input logic [17:0] e);
      ctl(ms, 1'b1, 1'b0, 1'b1, '0);
      put(1'b0, hl.idle());
      @(posedge i_clk);
      #1;
      chk(out_l.adr_oe_n, 1'b0);
      chk(out_l.adr, e);
   endtask : rb

   initial begin
      i_clk = 1'b0;
      forever #2 i_clk = ~i_clk;
   end

   initial begin
      repeat (20000) @(posedge i_clk);
      mismatches++;
      close_out();
   end

   initial begin
      i_nrst = 1'b0;
      oe_off = 1'b0;
      ce = 1'b1;
      mismatches = 0;
      tests_run = 0;
      repeat (11) @(posedge i_clk);
      #1;
      chk({out_l.mailbox_flag_n, out_r.mailbox_flag_n}, 2'b11);
      chk({out_l.wrap_flag_n, out_r.wrap_flag_n, out_l.adr_oe_n}, 3'b111);
      chk(out_l.dq_oe_n, 4'hf);
      @(posedge i_clk);
      i_nrst <= 1'b1;
      void'($urandom(94928));
      $display("test reset done");
      for (int i = 0; i < 24; i++) begin
         a = 18'($urandom_range(131069, 0));
         d1 = rword();
         d2 = rword();
         m = 4'($urandom);
         r = 4'($urandom);
         put(i[0], acc(1'b0, a, 4'h0, d1));
         put(i[0], acc(1'b0, a, m, d2));
         rd(!i[0], a, r, lane_mix('0, lane_mix(d1, d2, m), r));
      end
      $display("test random lanes done");
      fork
         hl.drive(acc(1'b1, a, 4'h0, '0));
         hr.drive(acc(1'b1, a, 4'h0, '0));
      join
      put(1'b0, hl.idle());
      @(posedge i_clk);
      #1;
      chk(out_l.dq, lane_mix(d1, d2, m));
      chk(out_r.dq, lane_mix(d1, d2, m));
      put(1'b0, acc(1'b1, a, 4'h0, '0));
      put(1'b0, hl.idle());
      @(posedge i_clk);
      #1;
      chk(out_l.dq_oe_n, 4'h0);
      oe_off = 1'b1;
      #1;
      chk(out_l.dq_oe_n, 4'hf);
      oe_off = 1'b0;
      for (int k = 0; k < 2; k++) begin
         if (k == 0) begin
            put(1'b0, '{default: '0, chip_sel_low_active_n: 1'b1, rd_wr_n: 1'b1});
         end else begin
            put(1'b0, '{default: '0, rd_wr_n: 1'b1});
         end
         put(1'b0, hl.idle());
         @(posedge i_clk);
         #1;
         chk(out_l.dq_oe_n, 4'hf);
      end
      $display("test enables done");
      for (int s = 0; s < 2; s++) begin
         a = s ? TOP - 18'h1 : TOP;
         d1 = rword();
         // full lanes on every mailbox access
         put(s[0], acc(1'b0, a, 4'h0, d1));
         put(s[0], hl.idle());
         @(posedge i_clk);
         #1;
         chk(flag(!s[0]), 1'b0);
         chk(flag(s[0]), 1'b1);
         rd(s[0], a, 4'h0, d1);
         chk(flag(!s[0]), 1'b0);
         rd(!s[0], a, 4'h0, d1);
         chk(flag(!s[0]), 1'b1);
      end
      $display("test mailbox done");
      // clock enable low: a mailbox write must not land
      @(posedge i_clk);
      ce <= 1'b0;
      put(1'b0, acc(1'b0, TOP, 4'h0, '0));
      put(1'b0, hl.idle());
      @(posedge i_clk);
      #1;
      chk(flag(1'b1), 1'b1);
      @(posedge i_clk);
      ce <= 1'b1;
      put(1'b0, hl.idle());
      @(posedge i_clk);
      #1;
      chk(flag(1'b1), 1'b1);
      $display("test clock enable done");
      ctl(1'b0, 1'b1, 1'b0, 1'b0, 18'h7);
      ctl(1'b1, 1'b1, 1'b0, 1'b0, 18'h105);
      ctl(1'b1, 1'b1, 1'b1, 1'b0, '0);
      ctl(1'b1, 1'b1, 1'b1, 1'b0, '0);
      put(1'b0, hl.idle());
      @(posedge i_clk);
      #1;
      chk(out_l.wrap_flag_n, 1'b0);
      rb(1'b1, 18'h107);
      ctl(1'b1, 1'b1, 1'b1, 1'b0, '0);
      rb(1'b1, 18'h100);
      ctl(1'b1, 1'b1, 1'b0, 1'b0, 18'h0aa);
      ctl(1'b1, 1'b0, 1'b0, 1'b0, 18'h055);
      rb(1'b1, 18'h0a8);
      rb(1'b0, 18'h7);
      ctl(1'b0, 1'b0, 1'b1, 1'b1, '0);
      rb(1'b0, 18'h1ffff);
      $display("test counter done");
      close_out();
   end
endmodule : test_dual_port_burst_sram_ports

`default_nettype wire
